// ==== rtl/ccm_pkg.sv ====
// Package: register map, field positions, reset values and timing counts for the channel mode block
// Overview of operation
// RULE1 - Reference is active high; pin follows polarity
// RULE2 - Mode 000 frozen: match changes nothing
// RULE3 - Mode 001 drives reference high on match
// RULE4 - Mode 010 drives reference low on match
// RULE5 - Mode 011 toggles reference on match
// RULE6 - Mode 100 forces inactive, 101 active
// RULE7 - Mode 110: active below compare counting up
// RULE8 - Mode 111: inverse of pulse-width mode one
// RULE9 - Pulse-width level changes only on compare change
// RULE10 - Buffer off: compare write applies immediately
// RULE11 - Buffer on: buffer copies in on update
// RULE12 - Unbuffered pulse-width only in single pulse; the block only stores the single-pulse bit and does not check it
// RULE13 - Fast off: trigger acts after five cycles
// RULE14 - Fast on: trigger forces compare within three
// RULE15 - Fast bit only counts in pulse-width modes
// RULE16 - Filter passes level after N agreeing samples
// RULE17 - Filter code selects sample rate and N
// RULE18 - Prescaler captures every 1, 2, 4, 6 events
// RULE19 - Selection: output, own, neighbour, trigger input
// RULE20 - Software picks internal trigger before code 11
// RULE21 - Selection changes only while channel disabled; the block accepts selection writes while enabled too
// RULE22 - Per-channel byte layout of mode fields
// RULE23 - Polarity 0 active high, 1 active low
// RULE24 - Pulse-width compare uses counter direction
package ccm_pkg;

	// Register byte addresses
	localparam logic [15:0] CCM_OFS_MODE12   = 16'he018;
	localparam logic [15:0] CCM_OFS_MODE34   = 16'he01c;
	localparam logic [15:0] CCM_OFS_ENABLE   = 16'he020;
	localparam logic [15:0] CCM_OFS_COMPARE0 = 16'he034;
	localparam logic [15:0] CCM_OFS_STATUS   = 16'he044;
	localparam logic [15:0] CCM_OFS_SINGLE   = 16'he048;

	// Reset values
	localparam logic [31:0] CCM_RST_MODE    = 32'h0000_0000;
	localparam logic [15:0] CCM_RST_COMPARE = 16'h0000;

	// Field positions inside one channel byte, odd-channel shift and enable-register polarity offset and stride
	localparam int CCM_SEL_LSB  = 0;
	localparam int CCM_FAST_BIT = 2;
	localparam int CCM_BUF_BIT  = 3;
	localparam int CCM_PSC_LSB  = 2;
	localparam int CCM_MODE_LSB = 4;
	localparam int CCM_FILT_LSB = 4;
	localparam int CCM_ODD_SHIFT = 8;
	localparam int CCM_POL_OFS  = 1;
	localparam int CCM_CH_STRIDE = 4;

	// Trigger reaction times in clock cycles
	localparam int CCM_TRIG_SLOW_CYC = 5;
	localparam int CCM_TRIG_FAST_CYC = 3;

	// Compare mode codes
	localparam logic [2:0] CCM_M_FROZEN = 3'h0;
	localparam logic [2:0] CCM_M_SET    = 3'h1;
	localparam logic [2:0] CCM_M_CLR    = 3'h2;
	localparam logic [2:0] CCM_M_TOGGLE = 3'h3;
	localparam logic [2:0] CCM_M_FLOW   = 3'h4;
	localparam logic [2:0] CCM_M_FHIGH  = 3'h5;
	localparam logic [2:0] CCM_M_PWM1   = 3'h6;
	localparam logic [2:0] CCM_M_PWM2   = 3'h7;

	// AXI responses
	localparam logic [1:0] CCM_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CCM_RESP_SLVERR = 2'h2;

endpackage

// ==== rtl/ccm_channel_mode.sv ====
// Four-channel capture/compare mode logic with AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module ccm_channel_mode
	import ccm_pkg::*;
#(
	parameter int CW = 16
) (
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          clk_en,
	// AXI4-Lite slave
	input  wire logic [15:0]   s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [15:0]   s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	// Counter core
	input  wire logic [CW-1:0] counter_value,
	input  wire logic          count_down,
	input  wire logic          update_event,
	input  wire logic          trigger_input,
	// Pins
	input  wire logic [3:0]    timer_input,
	output logic [3:0]         pin_output,
	output logic [3:0]         reference_wave,
	// Capture side
	output logic [3:0]         capture_strobe,
	output logic [3:0]         filtered_input
);

	// Configuration registers
	logic [31:0]   mode12_reg;           // Channels 1 and 2
	logic [31:0]   mode34_reg;           // Channels 3 and 4
	logic [15:0]   enable_reg;           // Enable and polarity pairs
	logic          single_pulse_reg;     // Single-pulse setting mirror
	logic [CW-1:0] cmp_buf_reg [4];      // Software-facing compare copy
	logic [CW-1:0] cmp_work_reg [4];     // Working compare value

	// Bus handshake state
	logic          aw_held_reg;
	logic          w_held_reg;
	logic [15:0]   awaddr_reg;
	logic [31:0]   wdata_reg;
	logic [3:0]    wstrb_reg;

	// Trigger synchroniser plus one stage for edge detection; trigger is asynchronous
	logic          trig_s1_reg;
	logic          trig_s2_reg;
	logic          trig_s3_reg;    // Previous synchronised level

	// Timer input synchronisers
	logic [3:0]    ti_s1_reg;
	logic [3:0]    ti_s2_reg;

	// Free-running sample-rate divider
	logic [4:0]    div_reg;

	// Trigger edge, sampled after the synchroniser
	wire trig_edge = trig_s2_reg & ~trig_s3_reg;

	// Write lands when address and data both held and no response pending
	wire wr_go = aw_held_reg & w_held_reg & ~s_axi_bvalid;

	// Byte-enable merge of a register word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Filter code to sample-rate divider exponent
	function automatic logic [2:0] filt_rate(input logic [3:0] f);
		logic [2:0] r;
		r = 3'h0;
		if (f >= 4'hd) r = 3'h5;
		else if (f >= 4'ha) r = 3'h4;
		else if (f >= 4'h8) r = 3'h3;
		else if (f >= 4'h6) r = 3'h2;
		else if (f >= 4'h4) r = 3'h1;
		return r;
	endfunction

	// Filter code to agreeing sample count
	function automatic logic [3:0] filt_n(input logic [3:0] f);
		logic [3:0] r;
		case (f)
			4'h0: r = 4'h1;
			4'h1: r = 4'h2;
			4'h2: r = 4'h4;
			4'ha, 4'hd: r = 4'h5;
			4'h4, 4'h6, 4'h8, 4'hb, 4'he: r = 4'h6;
			default: r = 4'h8;
		endcase
		return r;
	endfunction

	// AXI write address and data capture, either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg   <= 1'b0;
			w_held_reg    <= 1'b0;
			awaddr_reg    <= 16'h0000;
			wdata_reg     <= 32'h0000_0000;
			wstrb_reg     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else if (clk_en) begin
			// Ready pulses for one cycle when a channel is taken
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (wr_go) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
			end else begin
				if (s_axi_awvalid && !aw_held_reg && !s_axi_awready) begin
					aw_held_reg   <= 1'b1;
					awaddr_reg    <= s_axi_awaddr;
					s_axi_awready <= 1'b1;
				end
				if (s_axi_wvalid && !w_held_reg && !s_axi_wready) begin
					w_held_reg   <= 1'b1;
					wdata_reg    <= s_axi_wdata;
					wstrb_reg    <= s_axi_wstrb;
					s_axi_wready <= 1'b1;
				end
			end
		end
	end

	// Write response, unmapped address answers SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= CCM_RESP_OKAY;
		end else if (clk_en) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				case (awaddr_reg)
					CCM_OFS_MODE12, CCM_OFS_MODE34, CCM_OFS_ENABLE, CCM_OFS_SINGLE: s_axi_bresp <= CCM_RESP_OKAY;
					CCM_OFS_COMPARE0, CCM_OFS_COMPARE0 + 16'h4,
					CCM_OFS_COMPARE0 + 16'h8, CCM_OFS_COMPARE0 + 16'hc: s_axi_bresp <= CCM_RESP_OKAY;
					default: s_axi_bresp <= CCM_RESP_SLVERR;
				endcase
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Mode, enable and single-pulse registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode12_reg       <= CCM_RST_MODE;
			mode34_reg       <= CCM_RST_MODE;
			enable_reg       <= 16'h0000;
			single_pulse_reg <= 1'b0;
		end else if (clk_en && wr_go) begin
			// Selection bits are written freely; software keeps them steady while enabled
			if (awaddr_reg == CCM_OFS_MODE12) mode12_reg <= merge(mode12_reg, wdata_reg, wstrb_reg) & 32'h0000_ffff; // RULE22 RULE21
			if (awaddr_reg == CCM_OFS_MODE34) mode34_reg <= merge(mode34_reg, wdata_reg, wstrb_reg) & 32'h0000_ffff; // RULE22
			if (awaddr_reg == CCM_OFS_ENABLE) enable_reg <= 16'(merge({16'h0000, enable_reg}, wdata_reg, wstrb_reg) & 32'h0000_3333);
			if (awaddr_reg == CCM_OFS_SINGLE && wstrb_reg[0]) single_pulse_reg <= wdata_reg[0]; // RULE12
		end
	end

	// AXI read channel, one-cycle latency
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= CCM_RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid) begin
				if (s_axi_rready) s_axi_rvalid <= 1'b0;
			end else if (s_axi_arvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= CCM_RESP_OKAY;
				s_axi_rdata   <= 32'h0000_0000;
				case (s_axi_araddr)
					CCM_OFS_MODE12: s_axi_rdata <= mode12_reg;
					CCM_OFS_MODE34: s_axi_rdata <= mode34_reg;
					CCM_OFS_ENABLE: s_axi_rdata <= {16'h0000, enable_reg};
					CCM_OFS_SINGLE: s_axi_rdata <= {31'h0, single_pulse_reg};
					// Live status: reference in [3:0], filtered inputs in [7:4]
					CCM_OFS_STATUS: s_axi_rdata <= {24'h0, filtered_input, reference_wave};
					CCM_OFS_COMPARE0:         s_axi_rdata <= 32'(cmp_buf_reg[0]); // RULE11
					CCM_OFS_COMPARE0 + 16'h4: s_axi_rdata <= 32'(cmp_buf_reg[1]);
					CCM_OFS_COMPARE0 + 16'h8: s_axi_rdata <= 32'(cmp_buf_reg[2]);
					CCM_OFS_COMPARE0 + 16'hc: s_axi_rdata <= 32'(cmp_buf_reg[3]);
					default: s_axi_rresp <= CCM_RESP_SLVERR;
				endcase
			end
		end
	end

	// Trigger and timer input synchronisers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_s1_reg   <= 1'b0;
			trig_s2_reg   <= 1'b0;
			trig_s3_reg   <= 1'b0;
			ti_s1_reg     <= 4'h0;
			ti_s2_reg     <= 4'h0;
		end else if (clk_en) begin
			trig_s1_reg   <= trigger_input;
			trig_s2_reg   <= trig_s1_reg;
			trig_s3_reg   <= trig_s2_reg;
			ti_s1_reg     <= timer_input;
			ti_s2_reg     <= ti_s1_reg;
		end
	end

	// Shared sample-rate divider for all filters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= 5'h00;
		end else if (clk_en) begin
			div_reg <= div_reg + 5'h01;
		end
	end

	// Per-channel compare, reference and capture logic
	for (genvar c = 0; c < 4; c++) begin : g_ch
		// Odd-numbered byte holds channels 2 and 4
		wire [7:0]  cfg   = (c < 2) ? ((c % 2 == 1) ? mode12_reg[15:8] : mode12_reg[7:0])
		                            : ((c % 2 == 1) ? mode34_reg[15:8] : mode34_reg[7:0]); // RULE22
		wire [1:0]  sel   = cfg[CCM_SEL_LSB +: 2];
		wire [2:0]  mode  = cfg[CCM_MODE_LSB +: 3];
		wire        bufen = cfg[CCM_BUF_BIT];
		wire        fast  = cfg[CCM_FAST_BIT];
		wire [1:0]  psc   = cfg[CCM_PSC_LSB +: 2];
		wire [3:0]  filt  = cfg[CCM_FILT_LSB +: 4];
		wire        pol   = enable_reg[c*CCM_CH_STRIDE + CCM_POL_OFS];
		wire        ena   = enable_reg[c*CCM_CH_STRIDE];
		wire        pwm   = (mode == CCM_M_PWM1) || (mode == CCM_M_PWM2);
		wire        match = (counter_value == cmp_work_reg[c]);
		wire [15:0] my_ofs = CCM_OFS_COMPARE0 + 16'(c * 4);
		wire        wr_me = wr_go && (awaddr_reg == my_ofs);

		logic       ref_reg;     // Internal reference, active high
		logic       ref_next;    // Reference level for the coming edge
		logic       pwm_lvl;     // Pulse-width target level
		logic       cmp_lt;
		logic       cmp_gt;
		logic       trig_hit;
		logic       src;
		logic       filt_q_reg;
		logic [3:0] agree_reg;
		logic       last_reg;
		logic [2:0] evt_reg;
		logic [2:0] evt_lim;

		// Only the fast bit opens a direct trigger path; with it clear the reference follows
		// the compare and the trigger acts only through the counter core, which is slower
		assign trig_hit = pwm && fast && trig_edge; // RULE13 RULE14 RULE15

		// Compare buffer and working register
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				cmp_buf_reg[c]  <= CW'(CCM_RST_COMPARE);
				cmp_work_reg[c] <= CW'(CCM_RST_COMPARE);
			end else if (clk_en) begin
				if (wr_me) cmp_buf_reg[c] <= wdata_reg[CW-1:0];
				if (wr_me && !bufen) cmp_work_reg[c] <= wdata_reg[CW-1:0]; // RULE10
				else if (bufen && update_event) cmp_work_reg[c] <= cmp_buf_reg[c]; // RULE11
			end
		end

		// Pulse-width level from compare and direction
		always_comb begin
			cmp_lt = counter_value < cmp_work_reg[c];
			cmp_gt = counter_value > cmp_work_reg[c];
			if (!count_down) pwm_lvl = cmp_lt; // RULE24 RULE7
			else pwm_lvl = ~cmp_gt;
			if (mode == CCM_M_PWM2) pwm_lvl = ~pwm_lvl; // RULE8
		end

		// Next reference level; outputs load it at the same edge to keep the fast path short
		always_comb begin
			ref_next = ref_reg;
			if (sel == 2'h0) begin
				case (mode)
					CCM_M_FROZEN: ref_next = ref_reg; // RULE2
					CCM_M_SET:    if (match) ref_next = 1'b1; // RULE3
					CCM_M_CLR:    if (match) ref_next = 1'b0; // RULE4
					CCM_M_TOGGLE: if (match) ref_next = ~ref_reg; // RULE5
					CCM_M_FLOW:   ref_next = 1'b0; // RULE6
					CCM_M_FHIGH:  ref_next = 1'b1; // RULE6
					default:      ref_next = trig_hit ? (mode == CCM_M_PWM1) : pwm_lvl; // RULE9 RULE14
				endcase
			end
		end

		// Reference state; held while the channel is an input
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ref_reg <= 1'b0;
			end else if (clk_en) begin
				ref_reg <= ref_next;
			end
		end

		// Pin output and reference from flops, enable and polarity applied to the pin only
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pin_output[c]     <= 1'b0;
				reference_wave[c] <= 1'b0;
			end else if (clk_en) begin
				reference_wave[c] <= ref_next; // RULE1
				pin_output[c]     <= ena & (ref_next ^ pol); // RULE23 RULE1
			end
		end

		// Input source mux: own, neighbour, trigger
		always_comb begin
			case (sel)
				2'h1:    src = ti_s2_reg[c]; // RULE19
				2'h2:    src = ti_s2_reg[c ^ 1];
				2'h3:    src = trig_s2_reg;
				default: src = 1'b0;
			endcase
		end

		// Digital filter: N agreeing samples at the chosen rate
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				filt_q_reg <= 1'b0;
				agree_reg  <= 4'h0;
				last_reg   <= 1'b0;
			end else if (clk_en && ((div_reg & ((5'h01 << filt_rate(filt)) - 5'h01)) == 5'h00)) begin // RULE17
				last_reg <= src;
				if (src != last_reg) agree_reg <= 4'h1;
				else if (agree_reg < 4'hf) agree_reg <= agree_reg + 4'h1;
				if (((src == last_reg) ? agree_reg + 4'h1 : 4'h1) >= filt_n(filt)) filt_q_reg <= src; // RULE16
			end
		end

		// Capture prescaler on rising filtered edges
		always_comb begin
			case (psc)
				2'h1:    evt_lim = 3'h2; // RULE18
				2'h2:    evt_lim = 3'h4;
				2'h3:    evt_lim = 3'h6;
				default: evt_lim = 3'h1;
			endcase
		end

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				evt_reg           <= 3'h0;
				capture_strobe[c] <= 1'b0;
				filtered_input[c] <= 1'b0;
			end else if (clk_en) begin
				filtered_input[c] <= filt_q_reg;
				capture_strobe[c] <= 1'b0;
				// Only input channels that are enabled count edges
				if (sel != 2'h0 && ena && filt_q_reg && !filtered_input[c]) begin
					if (evt_reg + 3'h1 >= evt_lim) begin
						evt_reg           <= 3'h0;
						capture_strobe[c] <= 1'b1; // RULE18
					end else begin
						evt_reg <= evt_reg + 3'h1;
					end
				end
			end
		end
	end

endmodule

// ==== sim/ccm_channel_mode_properties.sv ====
// Checker for bus handshakes and pin polarity of the channel mode block
`timescale 1ns/100ps
module ccm_channel_mode_properties
	import ccm_pkg::*;
(
	input wire logic	aclk,
	input wire logic	aresetn,
	input wire logic	clk_en,
	input wire logic [15:0]	s_axi_awaddr,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic [31:0]	s_axi_wdata,
	input wire logic	s_axi_wready,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready,
	input wire logic [3:0]	pin_output,
	input wire logic [3:0]	reference_wave,
	input wire logic [3:0]	capture_strobe
);
	logic [15:0]	en_q;	// Shadow of enable and polarity bits
	logic [3:0]	pin_exp;	// Pin level implied by the shadow
	// Address and data arrive together, so one edge holds both
	always_ff @(posedge aclk) begin
		if (!aresetn)
			en_q <= '0;
		else if (clk_en && s_axi_awvalid && s_axi_awready && s_axi_wready && s_axi_awaddr == CCM_OFS_ENABLE)
			en_q <= s_axi_wdata[15:0];
	end
	// Gated and polarised reference per channel
	always_comb
		for (int i = 0; i < 4; i++)
			pin_exp[i] = en_q[4*i] & (reference_wave[i] ^ en_q[4*i+1]);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wtake; s_axi_awvalid && s_axi_awready; endsequence
	sequence s_rtake; s_axi_arvalid && s_axi_arready; endsequence
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	property p_awpulse; s_axi_awready |=> !s_axi_awready; endproperty
	property p_arpulse; $rose(s_axi_arready) |=> $fell(s_axi_arready); endproperty
	property p_wans; s_wtake |-> ##[0:3] s_axi_bvalid; endproperty
	property p_rans; s_rtake |-> ##[0:2] s_axi_rvalid; endproperty
	// Reset drives every output low, so no disable here
	property p_rst;
		disable iff (1'b0) !aresetn && clk_en |=> pin_output == 4'h0 && reference_wave == 4'h0 && capture_strobe == 4'h0;
	endproperty
	// Enable settled for three edges before the pin is judged
	property p_pin; en_q == $past(en_q, 3) |-> pin_output == pin_exp; endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped early");
	a_rhold: assert property (p_rhold) else $error("read answer changed early");
	a_awpulse: assert property (p_awpulse) else $error("awready longer than a pulse");
	a_arpulse: assert property (p_arpulse) else $error("arready longer than a pulse");
	a_wans: assert property (p_wans) else $error("write answer late");
	a_rans: assert property (p_rans) else $error("read answer late");
	a_rst: assert property (p_rst) else $error("output high after reset");
	a_pin: assert property (p_pin) else $error("pin differs from reference");
endmodule
bind ccm_channel_mode ccm_channel_mode_properties u_ccm_channel_mode_properties (.*);

// ==== sim/ccm_pin_model.sv ====
// Model of the sources on the timer input pins and the trigger line
`timescale 1ns/100ps
module ccm_pin_model (
	input wire logic	aclk,
	output logic [3:0]	timer_input,
	output logic	trigger_input
);
	// Quiet lines at start
	initial begin
		timer_input = '0;
		trigger_input = 1'b0;
	end
	// Levels move just after an edge, unrelated to the bus
	task automatic drive(input logic [3:0] tin, input logic trg);
		@(posedge aclk);
		timer_input <= tin;
		trigger_input <= trg;
	endtask
	// High for len cycles on the masked inputs; len must be above zero
	task automatic pulse(input logic [3:0] m, input int len);
		@(posedge aclk);
		timer_input <= timer_input | m;
		repeat (len) @(posedge aclk);
		timer_input <= timer_input & ~m;
	endtask
endmodule

// ==== sim/ccm_channel_mode_test.sv ====
// Register level bench for the channel mode block
`timescale 1ns/100ps
module ccm_channel_mode_test
	import ccm_pkg::*;
();
	logic	aclk = 0, aresetn = 0, clk_en = 1, count_down = 0, update_event = 0, seen;
	logic	s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [15:0]	s_axi_awaddr = '0, s_axi_araddr = '0, counter_value = 16'h0100;
	logic [31:0]	s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]	s_axi_wstrb = 4'hf, timer_input, pin_output, reference_wave, capture_strobe, filtered_input, sm;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	logic	s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, trigger_input;
	int	mismatches = 0, checked = 0, strobes = 0, n, fl, ds;
	// Mode, match and expected level per output step
	localparam logic [31:0] OSEQ = 32'h45332104;
	localparam logic [7:0] OHIT = 8'h3e, OEXP = 8'h54;
	// Filter length and log2 of sample divider per code
	localparam logic [63:0] FN = 64'h8658658686868421, FS = 64'h5554443322110000;
	ccm_channel_mode u_ccm_channel_mode (.*);
	ccm_pin_model u_ccm_pin_model (.*);
	always #20 aclk = ~aclk;
	// Captures seen on the third channel
	always @(posedge aclk) if (capture_strobe[2] === 1'b1) strobes <= strobes + 1;
	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge aclk);
	endtask
	// Each channel released at the edge that takes it
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er = CCM_RESP_OKAY);
		logic ap, wp;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		ap = 1'b1;
		wp = 1'b1;
		while (ap || wp) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) ap = 1'b0;
			if (s_axi_wready === 1'b1) wp = 1'b0;
			s_axi_awvalid <= ap;
			s_axi_wvalid <= wp;
		end
		while (s_axi_bvalid !== 1'b1) @(posedge aclk);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask
	// Data only judged on a good answer
	task automatic rdc(input logic [15:0] a, input logic [31:0] exp, input logic [1:0] er = CCM_RESP_OKAY);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1) @(posedge aclk);
		s_axi_rready <= 1'b0;
		chk(s_axi_rresp, er);
		if (er === CCM_RESP_OKAY) chk(s_axi_rdata, exp);
	endtask
	// One cycle of counter equal to the first compare value
	task automatic hit();
		@(posedge aclk);
		counter_value <= 16'h0010;
		@(posedge aclk);
		counter_value <= 16'h0100;
	endtask
	// Catches a short pulse on the second reference
	task automatic watch(input int c, output logic s);
		s = 1'b0;
		repeat (c) begin
			@(posedge aclk);
			if (reference_wave[1] === 1'b1) s = 1'b1;
		end
	endtask
	// Level for a counter k away from compare
	function automatic logic pwm(input int m, input int d, input int k);
		logic a;
		a = d ? !(k > 0) : (k < 0);
		return (m == 6) ? a : !a;
	endfunction
	initial begin
		cyc(8);
		aresetn <= 1'b1;
		rdc(CCM_OFS_MODE12, CCM_RST_MODE);
		rdc(CCM_OFS_MODE34, CCM_RST_MODE);
		rdc(CCM_OFS_COMPARE0, {16'h0, CCM_RST_COMPARE});
		rdc(16'he000, '0, CCM_RESP_SLVERR);
		wr(16'he004, 32'h1, CCM_RESP_SLVERR);
		wr(CCM_OFS_SINGLE, 32'h1);
		rdc(CCM_OFS_SINGLE, 32'h1);
		wr(CCM_OFS_COMPARE0, 32'h10);
		wr(CCM_OFS_ENABLE, 32'h1);
		for (int i = 0; i < 8; i++) begin
			wr(CCM_OFS_MODE12, {25'h0, OSEQ[4*i+:3], 4'h0});
			if (OHIT[i]) hit();
			cyc(6);
			chk(reference_wave[0], OEXP[i]);
			chk(pin_output[0], OEXP[i]);
		end
		wr(CCM_OFS_ENABLE, 32'h3);
		cyc(4);
		chk(pin_output[0], 1'b1);
		wr(CCM_OFS_COMPARE0 + 16'h4, 32'h40);
		for (int m = 6; m < 8; m++)
			for (int d = 0; d < 2; d++)
				for (int k = -1; k < 2; k++) begin
					count_down <= d[0];
					counter_value <= 16'(32'h40 + k);
					wr(CCM_OFS_MODE12, {16'h0, 1'h0, m[2:0], 12'h840});
					cyc(6);
					chk(reference_wave[1], pwm(m, d, k));
				end
		count_down <= 1'b0;
		counter_value <= 16'h0060;
		wr(CCM_OFS_MODE12, 32'h6840);
		wr(CCM_OFS_COMPARE0 + 16'h4, 32'h80);
		cyc(6);
		chk(reference_wave[1], 1'b0);
		rdc(CCM_OFS_COMPARE0 + 16'h4, 32'h80);
		update_event <= 1'b1;
		@(posedge aclk);
		update_event <= 1'b0;
		cyc(6);
		chk(reference_wave[1], 1'b1);
		rdc(CCM_OFS_STATUS, 32'h2);
		counter_value <= 16'h0090;
		cyc(6);
		u_ccm_pin_model.drive(4'h0, 1'b1);
		watch(8, seen);
		chk(seen, 1'b0);
		u_ccm_pin_model.drive(4'h0, 1'b0);
		wr(CCM_OFS_MODE12, 32'h6c40);
		u_ccm_pin_model.drive(4'h0, 1'b1);
		watch(4, seen);
		chk(seen, 1'b1);
		u_ccm_pin_model.drive(4'h0, 1'b0);
		wr(CCM_OFS_MODE12, 32'h4c40);
		wr(CCM_OFS_MODE12, 32'h1c40);
		u_ccm_pin_model.drive(4'h0, 1'b1);
		watch(8, seen);
		chk(seen, 1'b0);
		u_ccm_pin_model.drive(4'h0, 1'b0);
		// Third channel made an input while off, then enabled for capture
		wr(CCM_OFS_MODE34, 32'h1);
		wr(CCM_OFS_ENABLE, 32'h103);
		// Short pulse must vanish, long one must pass once
		for (int f = 0; f < 16; f++) begin
			wr(CCM_OFS_MODE34, {24'h0, f[3:0], 4'h1});
			n = strobes;
			ds = 1 << FS[4*f+:4];
			fl = int'(FN[4*f+:4]) * ds;
			if (f > 0) u_ccm_pin_model.pulse(4'h4, fl - ds);
			cyc(fl + 8);
			chk(strobes, n);
			u_ccm_pin_model.pulse(4'h4, fl + 2 * ds + 8);
			cyc(fl + 2 * ds + 8);
			chk(strobes, n + 1);
		end
		for (int p = 0; p < 4; p++) begin
			wr(CCM_OFS_MODE34, {28'h0, p[1:0], 2'h1});
			n = strobes;
			repeat (12) begin
				u_ccm_pin_model.pulse(4'h4, 4);
				cyc(6);
			end
			chk(strobes - n, 12 / (p == 3 ? 6 : 1 << p));
		end
		// Fourth channel source while its enable stays clear
		for (int s = 1; s < 4; s++) begin
			wr(CCM_OFS_MODE34, {22'h0, s[1:0], 8'h01});
			sm = s == 1 ? 4'h8 : s == 2 ? 4'h4 : 4'h0;
			u_ccm_pin_model.drive(sm, s == 3);
			cyc(8);
			chk(filtered_input[3], 1'b1);
			u_ccm_pin_model.drive(~sm, s != 3);
			cyc(8);
			chk(filtered_input[3], 1'b0);
		end
		tally_and_finish();
	end
	// Hang guard well past the expected run
	initial begin
		#2000000;
		mismatches++;
		tally_and_finish();
	end
endmodule
